// ---- src/smbus_master_end.sv ----
// Master end of the two-wire bus: command FIFO, link-clock bit engine,
// bus-free monitor and system-clock SCL low timeout.
// Assumes the bench supplies a free-running link clock and pull-ups.
//
// What this block does
// - Master opens with START, address, direction bit
// - Write: byte per slot, slave acks each
// - Read: slave sends, master acks each byte
// - Master ends transfer with STOP
// - Byte sender drives SDA during byte
// - Receiver drives ACK or NACK slot
// - Start only when bus free
// - Released-high SDA read low: arbitration lost
// - Loser stops driving, winner continues intact
// - Slave may stretch SCL low; master waits
// - SCL low beyond 25 ms is timeout
// - Timeout resets communication within 10 ms
// - Instance 0 uses timer 3, instance 1 timer 4
// - Timeout only when enable input set
// - Timer reloads while SCL high
`timescale 1ns/10ps
`default_nettype none

module smbus_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module smbus_master_end
  import smbus_pkg::*;
#(
  parameter int INSTANCE = 0,
  parameter int DEPTH    = FIFO_DEPTH,
  parameter int QTR      = QTR_CYC,
  parameter int FREE     = FREE_CYC,
  parameter int TIMEOUT  = TIMEOUT_CYC
) (
  // System clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Link clock
  input  wire logic             i_link_clk,
  // Command stream
  input  wire logic             i_cmd_valid,
  input  wire logic [CMD_W-1:0] i_cmd_data,
  output logic                  o_cmd_ready,
  // Configuration
  input  wire logic             i_scl_low_timeout_enable,
  // Responses
  output logic                  o_rsp_valid,
  output logic [BYTE_W-1:0]     o_rsp_rdata,
  output logic                  o_rsp_nack,
  output logic                  o_rsp_lost,
  output logic                  o_rsp_timeout,
  output logic                  o_scl_timeout,
  output logic [2:0]            o_timer_id,
  // Bus lines
  smbus_if.master               bus
);
  localparam int QW = $clog2(QTR);
  localparam int FW = $clog2(FREE + 1);
  localparam int TW = $clog2(TIMEOUT + 1);

  if (INSTANCE < 0 || INSTANCE > 1 || QTR < 2 || FREE < 1 || TIMEOUT < 2)
  begin : g_chk
    $error("Unsupported instance, quarter, free or timeout setting");
  end

  // ---------------- System clock domain ----------------
  logic             f_valid;
  logic [CMD_W-1:0] f_data;
  logic             launch;
  logic             pend_q;
  logic             req_t_q;
  logic [CMD_W-1:0] cmd_q;
  logic             dt1_q, dt2_q, dt3_q;
  logic             done_ev;
  logic             sc1_q, sc2_q;
  logic [TW-1:0]    tcnt_q;
  logic             abort_q;
  logic             tmo_hit;

  // Result held by the link domain until the next request
  logic [BYTE_W-1:0] rx_q;
  logic              nack_q, lost_q, tmo_q;
  logic              done_t_q;

  assign o_timer_id = (INSTANCE == 0) ? TIMER_FIRST : TIMER_SECOND;

  // Back-pressure: one transaction in flight, the FIFO fills behind it
  assign launch = f_valid && !pend_q;

  smbus_fifo #(.W(CMD_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_sys_rst),
    .i_in_valid  (i_cmd_valid),
    .i_in_data   (i_cmd_data),
    .o_in_ready  (o_cmd_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (launch)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pend_q  <= 1'b0;
      req_t_q <= 1'b0;
      cmd_q   <= '0;
    end else if (launch) begin
      cmd_q   <= f_data;
      req_t_q <= ~req_t_q;
      pend_q  <= 1'b1;
    end else if (done_ev) begin
      pend_q  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dt1_q <= 1'b0;
      dt2_q <= 1'b0;
      dt3_q <= 1'b0;
      sc1_q <= 1'b1;
      sc2_q <= 1'b1;
    end else begin
      dt1_q <= done_t_q;
      dt2_q <= dt1_q;
      dt3_q <= dt2_q;
      sc1_q <= bus.scl;
      sc2_q <= sc1_q;
    end
  end
  assign done_ev = dt2_q ^ dt3_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rsp_valid   <= 1'b0;
      o_rsp_rdata   <= '0;
      o_rsp_nack    <= 1'b0;
      o_rsp_lost    <= 1'b0;
      o_rsp_timeout <= 1'b0;
    end else begin
      o_rsp_valid <= done_ev;
      if (done_ev) begin
        o_rsp_rdata   <= rx_q;
        o_rsp_nack    <= nack_q;
        o_rsp_lost    <= lost_q;
        o_rsp_timeout <= tmo_q;
      end
    end
  end

  // Low timer; stops on the completion cycle so abort never sees set and
  // clear together
  assign tmo_hit = (tcnt_q == TW'(TIMEOUT - 1));
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_scl_low_timeout_enable || sc2_q || !pend_q) begin
      tcnt_q <= '0;
    end else if (!done_ev && tcnt_q != TW'(TIMEOUT)) begin
      tcnt_q <= tcnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_scl_timeout <= 1'b0;
      abort_q       <= 1'b0;
    end else begin
      o_scl_timeout <= tmo_hit && !done_ev && pend_q && !sc2_q;
      if (done_ev) begin
        abort_q <= 1'b0;
      end else if (o_scl_timeout) begin
        abort_q <= 1'b1;
      end
    end
  end

  // ---------------- Link clock domain ----------------
  logic             lr1_q, lr2_q;
  logic             rq1_q, rq2_q, rq3_q;
  logic             ab1_q, ab2_q;
  logic             scl1_q, scl2_q;
  logic             sda1_q, sda2_q, sda3_q;
  logic             new_req;
  logic             busy_q;
  logic [FW-1:0]    fcnt_q;
  mst_state_t       st_q;
  logic [1:0]       ph_q;
  logic [QW-1:0]    qc_q;
  logic             tick;
  logic             hold;
  logic [3:0]       bitn_q;
  logic             byte1_q;
  logic             rd_q;
  logic             tx;
  logic [BYTE_W-1:0] sh_q;
  logic [BYTE_W-1:0] wd_q;
  logic             scl_oe_n_q;
  logic             sda_oe_n_q;

  always_ff @(posedge i_link_clk) begin
    lr1_q  <= i_sys_rst;
    lr2_q  <= lr1_q;
    rq1_q  <= req_t_q;
    rq2_q  <= rq1_q;
    rq3_q  <= rq2_q;
    ab1_q  <= abort_q;
    ab2_q  <= ab1_q;
    scl1_q <= bus.scl;
    scl2_q <= scl1_q;
    sda1_q <= bus.sda;
    sda2_q <= sda1_q;
    sda3_q <= sda2_q;
  end
  assign new_req = rq2_q ^ rq3_q;

  // Bus busy from START until STOP or a long enough idle spell
  always_ff @(posedge i_link_clk) begin
    if (lr2_q) begin
      busy_q <= 1'b0;
      fcnt_q <= '0;
    end else begin
      fcnt_q <= (scl2_q && sda2_q) ?
                ((fcnt_q == FW'(FREE)) ? fcnt_q : fcnt_q + 1'b1) : '0;
      if (scl2_q && sda3_q && !sda2_q) begin
        busy_q <= 1'b1;
      end else if ((scl2_q && !sda3_q && sda2_q) || fcnt_q == FW'(FREE)) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign tick = (qc_q == QW'(QTR - 1));
  assign hold = (st_q == M_BIT || st_q == M_STOP) && ph_q == 2'd2 && !scl2_q;
  assign tx   = !byte1_q || !rd_q;

  always_ff @(posedge i_link_clk) begin
    if (lr2_q) begin
      st_q <= M_IDLE;
      ph_q <= 2'd0;
      qc_q <= '0;
      bitn_q <= '0;
      byte1_q <= 1'b0;
      rd_q <= 1'b0;
      sh_q <= '0;
      wd_q <= '0;
      rx_q <= '0;
      nack_q <= 1'b0;
      lost_q <= 1'b0;
      tmo_q <= 1'b0;
      done_t_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else if (ab2_q && st_q != M_IDLE && st_q != M_DONE) begin
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      tmo_q <= 1'b1;
      st_q <= M_DONE;
    end else begin
      qc_q <= (tick || hold || st_q == M_IDLE) ? '0 : qc_q + 1'b1;
      case (st_q)
        M_IDLE: begin
          ph_q <= 2'd0;
          if (new_req) begin
            rd_q <= cmd_q[CMD_RD_BIT];
            sh_q <= {cmd_q[CMD_ADDR_LSB +: ADDR_W], cmd_q[CMD_RD_BIT]};
            wd_q <= cmd_q[CMD_DATA_LSB +: BYTE_W];
            nack_q <= 1'b0;
            lost_q <= 1'b0;
            tmo_q <= 1'b0;
            st_q <= M_START;
          end
        end
        M_START: if (tick) begin
          if (ph_q == 2'd0 && !busy_q) begin
            sda_oe_n_q <= 1'b0;
            ph_q <= 2'd1;
          end else if (ph_q == 2'd1) begin
            scl_oe_n_q <= 1'b0;
            ph_q <= 2'd0;
            bitn_q <= '0;
            byte1_q <= 1'b0;
            st_q <= M_BIT;
          end
        end
        M_BIT: if (tick) begin
          case (ph_q)
            2'd0: begin
              if (bitn_q < 4'(ACK_BIT)) begin
                sda_oe_n_q <= tx ? sh_q[7] : 1'b1;
                sh_q <= {sh_q[6:0], 1'b1};
              end else begin
                sda_oe_n_q <= tx;
              end
              ph_q <= 2'd1;
            end
            2'd1: begin
              scl_oe_n_q <= 1'b1;
              ph_q <= 2'd2;
            end
            2'd2: begin
              ph_q <= 2'd3;
              if (bitn_q < 4'(ACK_BIT)) begin
                rx_q <= {rx_q[6:0], sda2_q};
                if (tx && sda_oe_n_q && !sda2_q) begin
                  sda_oe_n_q <= 1'b1;
                  lost_q <= 1'b1;
                  st_q <= M_DONE;
                end
              end else if (tx) begin
                nack_q <= sda2_q;
              end
            end
            default: begin
              scl_oe_n_q <= 1'b0;
              ph_q <= 2'd0;
              if (bitn_q == 4'(ACK_BIT)) begin
                bitn_q <= '0;
                if (byte1_q || nack_q) begin
                  st_q <= M_STOP;
                end else begin
                  byte1_q <= 1'b1;
                  sh_q <= wd_q;
                end
              end else begin
                bitn_q <= bitn_q + 1'b1;
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          case (ph_q)
            2'd0: sda_oe_n_q <= 1'b0;
            2'd1: scl_oe_n_q <= 1'b1;
            2'd2: ;
            default: begin
              sda_oe_n_q <= 1'b1;
              st_q <= M_DONE;
            end
          endcase
          ph_q <= ph_q + 1'b1;
        end
        default: begin
          done_t_q <= ~done_t_q;
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  assign bus.m_scl_o    = 1'b0;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_scl_oe_n = scl_oe_n_q;
  assign bus.m_sda_oe_n = sda_oe_n_q;
endmodule

`default_nettype wire

// ---- src/smbus_pkg.sv ----
// Shared constants and state types for the two-wire bus engine and its peer.
// Assumes a 40 MHz system clock; link-side counts are in link clock cycles.
package smbus_pkg;

  // Command word: {read, address[6:0], write data[7:0]}
  localparam int CMD_W        = 16;
  localparam int CMD_RD_BIT   = 15;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 0;
  localparam int ADDR_W       = 7;
  localparam int BYTE_W       = 8;
  localparam int ACK_BIT      = 8;

  localparam int FIFO_DEPTH = 8;

  // Timeout measured on the system clock
  localparam int TCK_NS             = 25;
  localparam int NS_PER_MS          = 1000000;
  localparam int SCL_LOW_TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = SCL_LOW_TIMEOUT_MS * (NS_PER_MS / TCK_NS);

  // Timer that each engine instance borrows for the low timeout
  localparam logic [2:0] TIMER_FIRST  = 3'h3;
  localparam logic [2:0] TIMER_SECOND = 3'h4;

  // Link clock cycles per quarter bit, and bus idle time counted as free
  localparam int QTR_CYC  = 4;
  localparam int FREE_CYC = 16;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BIT   = 5'h04,
    M_STOP  = 5'h08,
    M_DONE  = 5'h10
  } mst_state_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_ACK   = 7'h04,
    S_WDATA = 7'h08,
    S_RDATA = 7'h10,
    S_RACK  = 7'h20,
    S_SKIP  = 7'h40
  } slv_state_t;

endpackage

// ---- src/smbus_if.sv ----
// Open-drain clock and data lines shared by the master end and a slave end.
// Assumes every party drives a line only low; released lines read high.
`timescale 1ns/10ps
`default_nettype none

interface smbus_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_scl_o;
  logic s_scl_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND: any enabled low driver pulls the line low
  assign scl = !((!m_scl_oe_n && !m_scl_o) || (!s_scl_oe_n && !s_scl_o));
  assign sda = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));

  modport master (
    input  scl,
    input  sda,
    output m_scl_o,
    output m_scl_oe_n,
    output m_sda_o,
    output m_sda_oe_n
  );

  modport slave (
    input  scl,
    input  sda,
    output s_scl_o,
    output s_scl_oe_n,
    output s_sda_o,
    output s_sda_oe_n
  );

endinterface

`default_nettype wire

// ---- src/smbus_slave_end.sv ----
// Slave end of the two-wire bus: address match, byte receive and send,
// acknowledge driving and optional clock stretching.
// Assumes SCL low phases last several system clock cycles.
`timescale 1ns/10ps
`default_nettype none

module smbus_slave_end
  import smbus_pkg::*;
#(
  parameter logic [ADDR_W-1:0] OWN_ADDR = 7'h2A
) (
  // System clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // Byte served on reads, stretch request
  input  wire logic [BYTE_W-1:0] i_tx_data,
  input  wire logic              i_stretch,
  // Received write bytes
  output logic                   o_rx_valid,
  output logic [BYTE_W-1:0]      o_rx_data,
  // Bus lines
  smbus_if.slave                 bus
);
  logic sc1_q, sc2_q, sc3_q;
  logic sd1_q, sd2_q, sd3_q;
  logic rise, fall, start, stop;
  slv_state_t        st_q;
  logic [2:0]        cnt_q;
  logic [BYTE_W-1:0] sh_q;
  logic [BYTE_W-1:0] tsh_q;
  logic              rw_q;
  logic              ackon_q;
  logic              sda_oe_n_q;
  logic              scl_oe_n_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      {sc1_q, sc2_q, sc3_q} <= 3'h7;
      {sd1_q, sd2_q, sd3_q} <= 3'h7;
    end else begin
      {sc1_q, sc2_q, sc3_q} <= {bus.scl, sc1_q, sc2_q};
      {sd1_q, sd2_q, sd3_q} <= {bus.sda, sd1_q, sd2_q};
    end
  end

  assign rise  = sc2_q && !sc3_q;
  assign fall  = !sc2_q && sc3_q;
  assign start = sc2_q && sc3_q && sd3_q && !sd2_q;
  assign stop  = sc2_q && sc3_q && !sd3_q && sd2_q;

  // Stretch only once the line is already low, so no false edge appears
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_oe_n_q <= 1'b1;
    end else begin
      scl_oe_n_q <= !(i_stretch && !sc2_q);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= '0;
    end else begin
      o_rx_valid <= (st_q == S_WDATA) && rise && (cnt_q == 3'h7);
      if ((st_q == S_WDATA) && rise && (cnt_q == 3'h7)) begin
        o_rx_data <= {sh_q[6:0], sd2_q};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      tsh_q <= '0;
      rw_q <= 1'b0;
      ackon_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop) begin
      st_q <= S_IDLE;
      sda_oe_n_q <= 1'b1;
    end else if (start) begin
      st_q <= S_ADDR;
      cnt_q <= '0;
      ackon_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        S_ADDR: if (rise) begin
          sh_q <= {sh_q[6:0], sd2_q};
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 3'h7) begin
            rw_q <= sd2_q;
            st_q <= (sh_q[ADDR_W-1:0] == OWN_ADDR) ? S_ACK : S_SKIP;
          end
        end
        S_ACK: if (fall) begin
          if (!ackon_q) begin
            sda_oe_n_q <= 1'b0;
            ackon_q <= 1'b1;
          end else begin
            ackon_q <= 1'b0;
            cnt_q <= '0;
            if (rw_q) begin
              sda_oe_n_q <= i_tx_data[7];
              tsh_q <= {i_tx_data[6:0], 1'b1};
              st_q <= S_RDATA;
            end else begin
              sda_oe_n_q <= 1'b1;
              st_q <= S_WDATA;
            end
          end
        end
        S_WDATA: if (rise) begin
          sh_q <= {sh_q[6:0], sd2_q};
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 3'h7) begin
            st_q <= S_ACK;
          end
        end
        S_RDATA: begin
          if (fall) begin
            sda_oe_n_q <= tsh_q[7];
            tsh_q <= {tsh_q[6:0], 1'b1};
          end else if (rise) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == 3'h7) begin
              st_q <= S_RACK;
            end
          end
        end
        S_RACK: begin
          if (fall) begin
            sda_oe_n_q <= 1'b1;
          end else if (rise) begin
            st_q <= S_SKIP;
          end
        end
        default: sda_oe_n_q <= 1'b1;
      endcase
    end
  end

  assign bus.s_scl_o    = 1'b0;
  assign bus.s_sda_o    = 1'b0;
  assign bus.s_scl_oe_n = scl_oe_n_q;
  assign bus.s_sda_oe_n = sda_oe_n_q;
endmodule

`default_nettype wire

// ---- tb/smbus_asserts.sv ----
// Checker for the lines between the master end and the slave end.
// Assumes it watches the first bus only, where both parties are designs.
`timescale 1ns/10ps
`default_nettype none

module smbus_asserts (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_link_clk,
  input wire logic i_sys_rst,
  // Enables and resolved lines
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n,
  input wire logic s_scl_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic [4:0] bits_q;
  logic       rd_q;

  // Rises since the last start; saturates so stray rises stay harmless
  always_ff @(posedge i_link_clk) begin
    if (i_sys_rst || ($fell(sda) && scl)) begin
      bits_q <= 5'h00;
    end else if ($rose(scl) && bits_q != 5'h1F) begin
      bits_q <= bits_q + 5'h01;
    end
  end

  // Direction bit, taken at the eighth rise
  always_ff @(posedge i_link_clk) begin
    if (i_sys_rst) begin
      rd_q <= 1'b0;
    end else if ($rose(scl) && bits_q == 5'h07) begin
      rd_q <= sda;
    end
  end

  start_hold_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst) $fell(sda) && scl |-> scl [*3] ##[1:6] !scl)
    else $error("start without clock low");
  stop_idle_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst) $rose(sda) && scl |-> (sda && scl) [*3])
    else $error("bus not idle after stop");
  slave_edge_a: assert property (@(posedge i_clk)
    disable iff (i_sys_rst) $changed(s_sda_oe_n) |-> !scl)
    else $error("slave moved data while clock high");
  addr_quiet_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst) $rose(scl) && bits_q < 5'h08 |-> s_sda_oe_n)
    else $error("slave drove data during address");
  ack_free_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst) $rose(scl) && bits_q == 5'h08 |-> m_sda_oe_n)
    else $error("master drove address ack slot");
  write_ack_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst)
    $rose(scl) && bits_q == 5'h11 && !rd_q |-> m_sda_oe_n && !sda)
    else $error("write byte not acked by slave");
  read_ack_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst)
    $rose(scl) && bits_q == 5'h11 && rd_q |-> !m_sda_oe_n)
    else $error("master did not ack read byte");
  stretch_high_a: assert property (@(posedge i_link_clk)
    disable iff (i_sys_rst) $rose(scl) |-> scl [*3])
    else $error("clock high phase cut short");

  cover property (@(posedge i_link_clk) $rose(scl) && bits_q == 5'h11 && rd_q);
  cover property (@(posedge i_link_clk) $rose(scl) && bits_q == 5'h11 && !rd_q);
  cover property (@(posedge i_clk) $fell(s_scl_oe_n));
endmodule

`default_nettype wire

// ---- tb/test_smbus_protocol_engine.sv ----
// Bench: master and slave ends on one bus; a second master on a bus
// that the bench drives itself, for the busy and lost-arbitration cases.
`timescale 1ns/10ps
`default_nettype none

module test_smbus_protocol_engine;
  import smbus_pkg::*;
  // Timeout shortened so the run stays short
  localparam int TO    = 200;
  localparam int LIMIT = 40000;

  logic        i_clk      = 1'b0;
  logic        i_link_clk = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic        v_a        = 1'b0;
  logic        v_b        = 1'b0;
  logic [15:0] cmd_data   = 16'h0000;
  logic        to_en      = 1'b1;
  logic [7:0]  tx_data    = 8'h3C;
  logic        stretch    = 1'b0;
  logic        drv_sda_n  = 1'b1;
  logic        rdy_a, rsp_a, nack_a, lost_a, tout_a, scl_to;
  logic        rdy_b, rsp_b, nack_b, lost_b, rx_valid;
  logic [7:0]  rdata_a, rx_data;
  logic [2:0]  tid_a, tid_b;
  logic [7:0]  rx_q[$];
  int          n_errors, num_checks, n_rsp, n_to, cyc, low_cnt, low_at_to;
  int          base, k;

  always #12.5 i_clk = !i_clk;
  always #24 i_link_clk = !i_link_clk;

  smbus_if bus_a ();
  smbus_if bus_b ();
  // Bench stands in for the far side of the second bus, data line only
  assign bus_b.s_scl_o    = 1'b0;
  assign bus_b.s_sda_o    = 1'b0;
  assign bus_b.s_scl_oe_n = 1'b1;
  assign bus_b.s_sda_oe_n = drv_sda_n;

  smbus_master_end #(.INSTANCE(0), .TIMEOUT(TO)) i_smbus_master_end (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
    .i_cmd_valid(v_a), .i_cmd_data(cmd_data), .o_cmd_ready(rdy_a),
    .i_scl_low_timeout_enable(to_en), .o_rsp_valid(rsp_a),
    .o_rsp_rdata(rdata_a), .o_rsp_nack(nack_a), .o_rsp_lost(lost_a),
    .o_rsp_timeout(tout_a), .o_scl_timeout(scl_to), .o_timer_id(tid_a),
    .bus(bus_a));
  smbus_slave_end i_smbus_slave_end (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_data(tx_data),
    .i_stretch(stretch), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .bus(bus_a));
  smbus_master_end #(.INSTANCE(1), .TIMEOUT(TO)) i_smbus_master_end_b (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
    .i_cmd_valid(v_b), .i_cmd_data(cmd_data), .o_cmd_ready(rdy_b),
    .i_scl_low_timeout_enable(1'b0), .o_rsp_valid(rsp_b),
    .o_rsp_rdata(), .o_rsp_nack(nack_b), .o_rsp_lost(lost_b),
    .o_rsp_timeout(), .o_scl_timeout(), .o_timer_id(tid_b), .bus(bus_b));
  smbus_asserts i_smbus_asserts (
    .i_clk(i_clk), .i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst),
    .m_sda_oe_n(bus_a.m_sda_oe_n), .s_sda_oe_n(bus_a.s_sda_oe_n),
    .s_scl_oe_n(bus_a.s_scl_oe_n), .scl(bus_a.scl), .sda(bus_a.sda));

  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Valid stays up after the take; the caller lowers it
  task automatic send(input logic b, input logic [15:0] cmd);
    int n;
    n = 0;
    cmd_data = cmd;
    if (b) begin
      v_b = 1'b1;
    end else begin
      v_a = 1'b1;
    end
    do begin
      @(posedge i_clk);
      n++;
    end while ((b ? rdy_b : rdy_a) !== 1'b1 && n < 4000);
    #1;
    check("command taken", 16'(n < 4000), 16'h0001);
  endtask

  task automatic wait_rsp(input int want);
    int n;
    n = 0;
    while (n_rsp < want && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    #1;
    check("response seen", 16'(n_rsp >= want), 16'h0001);
  endtask

  task automatic run(input logic b, input logic [15:0] cmd);
    int want;
    want = n_rsp + 1;
    send(b, cmd);
    v_a = 1'b0;
    v_b = 1'b0;
    wait_rsp(want);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    low_cnt = bus_a.scl ? 0 : low_cnt + 1;
    if (rsp_a || rsp_b) n_rsp++;
    if (rx_valid) rx_q.push_back(rx_data);
    if (scl_to) begin
      n_to++;
      low_at_to = low_cnt;
    end
    if (cyc == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    // Link side leaves reset later, through its own sync stages
    repeat (6) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    run(1'b0, {1'b0, 7'h2A, 8'hA5});
    check("write nack", nack_a, 1'b0);
    check("write lost", lost_a, 1'b0);
    check("write byte", rx_q.pop_front(), 8'hA5);
    run(1'b0, {1'b1, 7'h2A, 8'h00});
    check("read byte", rdata_a, 8'h3C);
    check("read nack", nack_a, 1'b0);
    run(1'b0, {1'b0, 7'h15, 8'h77});
    check("absent nack", nack_a, 1'b1);
    check("absent rx", 16'(rx_q.size()), 16'h0000);
    check("no early timeout", 16'(n_to), 16'h0000);
    $display("test basic done");
    // Queue fills while the slave stretches with the timeout switched off
    to_en = 1'b0;
    stretch = 1'b1;
    base = n_rsp;
    for (int i = 0; i < 9; i++) begin
      send(1'b0, {1'b0, 7'h2A, 8'(8'hC0 + i)});
    end
    v_a = 1'b0;
    check("queue refuses", rdy_a, 1'b0);
    repeat (400) @(posedge i_clk);
    #1;
    check("off means no timeout", 16'(n_to), 16'h0000);
    stretch = 1'b0;
    send(1'b0, {1'b0, 7'h2A, 8'hC9});
    v_a = 1'b0;
    wait_rsp(base + 10);
    check("drained count", 16'(rx_q.size()), 16'h000A);
    for (int i = 0; i < 10; i++) begin
      check("queued byte", rx_q.pop_front(), 8'(8'hC0 + i));
    end
    $display("test queue done");
    // Clock held low past the limit, then a clean transfer
    to_en = 1'b1;
    stretch = 1'b1;
    run(1'b0, {1'b0, 7'h2A, 8'h5A});
    check("timeout flag", tout_a, 1'b1);
    check("timeout pulses", 16'(n_to), 16'h0001);
    check("low span", 16'(low_at_to >= TO && low_at_to <= TO + 6), 16'h0001);
    check("lines freed", {bus_a.m_scl_oe_n, bus_a.m_sda_oe_n}, 2'b11);
    stretch = 1'b0;
    run(1'b0, {1'b0, 7'h2A, 8'h66});
    check("recovered byte", rx_q.pop_front(), 8'h66);
    check("recovered flag", tout_a, 1'b0);
    check("timer first", tid_a, 3'h3);
    check("timer second", tid_b, 3'h4);
    $display("test timeout done");
    // Busy second bus, then a lost first address bit, then a retry
    drv_sda_n = 1'b0;
    base = n_rsp;
    send(1'b1, {1'b0, 7'h55, 8'h00});
    v_b = 1'b0;
    repeat (120) @(posedge i_clk);
    #1;
    check("waits while busy", {bus_b.m_scl_oe_n, bus_b.m_sda_oe_n}, 2'b11);
    drv_sda_n = 1'b1;
    k = 0;
    while (bus_b.scl !== 1'b0 && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    #1;
    check("clock low seen", bus_b.scl, 1'b0);
    drv_sda_n = 1'b0;
    wait_rsp(base + 1);
    check("lost flag", lost_b, 1'b1);
    check("loser released", {bus_b.m_scl_oe_n, bus_b.m_sda_oe_n}, 2'b11);
    drv_sda_n = 1'b1;
    run(1'b1, {1'b0, 7'h55, 8'h00});
    check("retry lost", lost_b, 1'b0);
    check("retry nack", nack_b, 1'b1);
    $display("test arbitration done");
    end_sim();
  end
endmodule

`default_nettype wire
